// ### design/emtc_top.v
// external memory timing configuration: area-2 dram, card strobes, mode set
//
// Summary of operation
// - area-2 dram control is 16 bits, cleared only by power-on reset.
// - with dram in area 2 its bus is 16 bits; software sets others.
// - bits 15:14 give precharge 1-4 cycles, 2/5/8/11 after self-refresh.
// - bits 13:12 give row-to-column delay of 1 to 4 cycles.
// - bits 9:8 give refresh row strobe time of 2 to 5 cycles.
// - bit 6 enables fast page mode bursts; zero disables bursts.
// - bits 4:3 select column address width of 8 to 11 bits.
// - bit 2 enables refresh of area-2 memory.
// - bit 1 picks row-strobe-later or self refresh, only when enabled.
// - ordinary refresh request ends the running bus cycle on the same edge as the refresh starts.
// - self-refresh waits for the bus cycle; requests ignored while in it.
// - card strobe timing is 16 bits, cleared only by power-on reset.
// - card timing bits 15:8 read zero; software writes zero.
// - strobe lead codes give 0.5 to 3.5 cycle delays per area.
// - strobe trail codes give 0.5 to 3.5 cycle delays per area.
// - card strobe width comes from the wait control register.
// - mode setting is write-only; value travels on the address bus.
// - memory receives the mode offset shifted right by two.
// - areas 2 and 3 have separate mode windows, each for its own area.
`timescale 1ns/100ps
`default_nettype none
`include "emtc_defines.vh"
module emtc_top
(
   // clock and power-on reset
   input wire clk,
   input wire resetn,
   // internal register access
   input wire reg_wr,
   input wire reg_rd,
   input wire [`EMTC_ADDR_W-1:0] reg_addr,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata_r,
   // bus cycle and refresh timer status
   input wire bus_busy,
   input wire refresh_req,
   input wire self_refresh_exit,
   input wire [1:0] wait_strobe_width,
   // area-2 dram timing outputs
   output reg [3:0] precharge_cycles_r,
   output reg [2:0] row_to_column_cycles_r,
   output reg [2:0] refresh_ras_cycles_r,
   output reg burst_enable_r,
   output reg [3:0] column_width_r,
   output reg area2_bus16_r,
   // refresh sequencing
   output reg bus_abort_r,
   output reg cbr_refresh_r,
   output reg in_self_refresh_r,
   // card strobe timing, in half cycles
   output reg [2:0] area5_lead_half_r,
   output reg [2:0] area6_lead_half_r,
   output reg [2:0] area5_trail_half_r,
   output reg [2:0] area6_trail_half_r,
   output reg [1:0] card_strobe_width_r,
   // mode-register-set command
   output wire mrs_area2,
   output wire mrs_area3,
   output wire [`EMTC_MODE_MSB:0] mrs_addr
);
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_CBR = 2'b01;
   localparam [1:0] ST_SR_WAIT = 2'b10;
   localparam [1:0] ST_SR = 2'b11;

   reg rst_s1_r;
   reg rst_n_r;
   wire [15:0] a2dc;
   wire [15:0] cst;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   wire wr_a2dc;
   wire wr_cst;
   wire in_win2;
   wire in_win3;
   wire rf_on;
   wire rf_self;
   wire hit_a2dc;
   wire hit_cst;
   reg [3:0] precharge_nxt;
   reg [2:0] area5_lead_half_nxt;
   reg [2:0] area6_lead_half_nxt;
   reg [2:0] area5_trail_half_nxt;
   reg [2:0] area6_trail_half_nxt;

   // half-cycle count for a lead or trail code: 2 * code + 1
   function [2:0] half_cycles;
      input [1:0] code;
      begin
         half_cycles = {code, 1'b1};
      end
   endfunction

   function in_window;
      input [`EMTC_ADDR_W-1:0] a;
      input [`EMTC_ADDR_W-1:0] base;
      begin
         in_window = a[`EMTC_SMMS_HI_MSB:`EMTC_SMMS_HI_LSB] ==
            base[`EMTC_SMMS_HI_MSB:`EMTC_SMMS_HI_LSB];
      end
   endfunction

   // release passes two flops so no flop leaves reset near an edge
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // one write per cycle while reg_wr is high; nothing is posted or queued
   assign hit_a2dc = reg_addr == `EMTC_A2DC_ADDR;
   assign hit_cst = reg_addr == `EMTC_CST_ADDR;
   assign wr_a2dc = reg_wr & hit_a2dc;
   assign wr_cst = reg_wr & hit_cst;
   assign in_win2 = in_window(reg_addr, `EMTC_SMMS2_BASE);
   assign in_win3 = in_window(reg_addr, `EMTC_SMMS3_BASE);

   // only power-on reset clears it; no other reset exists here
   emtc_cfg_reg #(
      .RESET_VAL(`EMTC_A2DC_RESET),
      .WMASK(`EMTC_A2DC_WMASK)
   ) u_a2dc (
      .clk(clk),
      .rst_n(rst_n_r),
      .wr_en(wr_a2dc),
      .wr_data(reg_wdata),
      .q_r(a2dc)
   );

   emtc_cfg_reg #(
      .RESET_VAL(`EMTC_CST_RESET),
      .WMASK(`EMTC_CST_WMASK)
   ) u_cst (
      .clk(clk),
      .rst_n(rst_n_r),
      .wr_en(wr_cst),
      .wr_data(reg_wdata),
      .q_r(cst)
   );

   // data bus is ignored on window writes; offset comes from the address
   emtc_mode_issue u_mode (
      .clk(clk),
      .rst_n(rst_n_r),
      .req(reg_wr & (in_win2 | in_win3)),
      .req_area3(in_win3),
      .req_offset(reg_addr[`EMTC_SMMS_SPAN_MSB:0]),
      .mrs_area2_r(mrs_area2),
      .mrs_area3_r(mrs_area3),
      .mrs_addr_r(mrs_addr)
   );

   // window reads return zero: the mode setting is write-only
   always @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
         reg_rdata_r <= 16'h0000;
      else if (reg_rd)
      begin
         if (hit_a2dc)
            reg_rdata_r <= a2dc;
         else if (hit_cst)
            reg_rdata_r <= cst;
         else
            reg_rdata_r <= 16'h0000;
      end
   end

   assign rf_on = a2dc[`EMTC_RFON_BIT];
   assign rf_self = a2dc[`EMTC_RFKIND_BIT];

   // self-refresh outranks an ordinary request while both are enabled
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
         begin
            if (rf_on & rf_self)
               state_nxt = bus_busy ? ST_SR_WAIT : ST_SR;
            else if (rf_on & refresh_req)
               state_nxt = ST_CBR;
         end
         ST_CBR:
            // a held request comes back every other cycle
            state_nxt = ST_IDLE;
         ST_SR_WAIT:
         begin
            if (!(rf_on & rf_self))
               state_nxt = ST_IDLE;
            else if (!bus_busy)
               state_nxt = ST_SR;
         end
         ST_SR:
         begin
            // refresh requests are not looked at here
            if (!(rf_on & rf_self))
               state_nxt = ST_IDLE;
         end
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   // post-self-refresh table applies only while the exit flag is up
   always @*
   begin
      if (self_refresh_exit)
         precharge_nxt = `EMTC_PRE_SR_BASE +
            `EMTC_PRE_SR_STEP *
            {2'h0, a2dc[`EMTC_PRE_MSB:`EMTC_PRE_LSB]};
      else
         precharge_nxt = `EMTC_PRE_BASE +
            {2'h0, a2dc[`EMTC_PRE_MSB:`EMTC_PRE_LSB]};
   end

   always @*
   begin
      area5_lead_half_nxt =
         half_cycles(cst[`EMTC_A5LEAD_MSB:`EMTC_A5LEAD_LSB]);
      area6_lead_half_nxt =
         half_cycles(cst[`EMTC_A6LEAD_MSB:`EMTC_A6LEAD_LSB]);
      area5_trail_half_nxt =
         half_cycles(cst[`EMTC_A5TRAIL_MSB:`EMTC_A5TRAIL_LSB]);
      area6_trail_half_nxt =
         half_cycles(cst[`EMTC_A6TRAIL_MSB:`EMTC_A6TRAIL_LSB]);
   end

   // refresh sequencing
   always @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         state_r <= ST_IDLE;
         bus_abort_r <= 1'b0;
         cbr_refresh_r <= 1'b0;
         in_self_refresh_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         bus_abort_r <= (state_nxt == ST_CBR) & bus_busy;
         cbr_refresh_r <= state_nxt == ST_CBR;
         in_self_refresh_r <= state_nxt == ST_SR;
      end
   end

   // area-2 dram timing follows the register one edge later
   always @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         precharge_cycles_r <= `EMTC_PRE_BASE;
         row_to_column_cycles_r <= `EMTC_RCD_BASE;
         refresh_ras_cycles_r <= `EMTC_RAS_BASE;
         burst_enable_r <= 1'b0;
         column_width_r <= `EMTC_COL_BASE;
         area2_bus16_r <= 1'b1;
      end
      else
      begin
         precharge_cycles_r <= precharge_nxt;
         row_to_column_cycles_r <= `EMTC_RCD_BASE +
            {1'b0, a2dc[`EMTC_RCD_MSB:`EMTC_RCD_LSB]};
         refresh_ras_cycles_r <= `EMTC_RAS_BASE +
            {1'b0, a2dc[`EMTC_RAS_MSB:`EMTC_RAS_LSB]};
         burst_enable_r <= a2dc[`EMTC_BURST_BIT];
         column_width_r <= `EMTC_COL_BASE +
            {2'h0, a2dc[`EMTC_COL_MSB:`EMTC_COL_LSB]};
         area2_bus16_r <= 1'b1;
      end
   end

   // card strobe timing; the pulse width itself belongs to wait control
   always @(posedge clk or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         area5_lead_half_r <= 3'h1;
         area6_lead_half_r <= 3'h1;
         area5_trail_half_r <= 3'h1;
         area6_trail_half_r <= 3'h1;
         card_strobe_width_r <= 2'h0;
      end
      else
      begin
         area5_lead_half_r <= area5_lead_half_nxt;
         area6_lead_half_r <= area6_lead_half_nxt;
         area5_trail_half_r <= area5_trail_half_nxt;
         area6_trail_half_r <= area6_trail_half_nxt;
         card_strobe_width_r <= wait_strobe_width;
      end
   end
endmodule
`default_nettype wire

// ### design/emtc_defines.vh
// constants for the external memory timing configuration block
`ifndef EMTC_DEFINES_VH
`define EMTC_DEFINES_VH
`define EMTC_ADDR_W 28
`define EMTC_A2DC_ADDR 28'hFFFFF00
`define EMTC_CST_ADDR 28'hFFFFF04
`define EMTC_SMMS2_BASE 28'hFFFD000
`define EMTC_SMMS3_BASE 28'hFFFE000
`define EMTC_SMMS_SPAN_MSB 11
`define EMTC_SMMS_HI_MSB 27
`define EMTC_SMMS_HI_LSB 12
`define EMTC_A2DC_RESET 16'h0000
`define EMTC_CST_RESET 16'h0000
`define EMTC_A2DC_WMASK 16'hF35E
`define EMTC_CST_WMASK 16'h00FF
`define EMTC_PRE_MSB 15
`define EMTC_PRE_LSB 14
`define EMTC_RCD_MSB 13
`define EMTC_RCD_LSB 12
`define EMTC_RAS_MSB 9
`define EMTC_RAS_LSB 8
`define EMTC_BURST_BIT 6
`define EMTC_COL_MSB 4
`define EMTC_COL_LSB 3
`define EMTC_RFON_BIT 2
`define EMTC_RFKIND_BIT 1
`define EMTC_A5LEAD_MSB 7
`define EMTC_A5LEAD_LSB 6
`define EMTC_A6LEAD_MSB 5
`define EMTC_A6LEAD_LSB 4
`define EMTC_A5TRAIL_MSB 3
`define EMTC_A5TRAIL_LSB 2
`define EMTC_A6TRAIL_MSB 1
`define EMTC_A6TRAIL_LSB 0
`define EMTC_MODE_MSB 9
`define EMTC_MODE_SHIFT 2
`define EMTC_PRE_BASE 4'h1
`define EMTC_PRE_SR_BASE 4'h2
`define EMTC_PRE_SR_STEP 4'h3
`define EMTC_RCD_BASE 3'h1
`define EMTC_RAS_BASE 3'h2
`define EMTC_COL_BASE 4'h8
`endif

// ### design/emtc_cfg_reg.v
// power-on-only cleared configuration register with write mask
`timescale 1ns/100ps
`default_nettype none
module emtc_cfg_reg
#(
   parameter [15:0] RESET_VAL = 16'h0000,
   parameter [15:0] WMASK = 16'hFFFF
)
(
   // clock and power-on reset
   input wire clk,
   input wire rst_n,
   // write port
   input wire wr_en,
   input wire [15:0] wr_data,
   // stored value, unused bits zero
   output reg [15:0] q_r
);
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         q_r <= RESET_VAL;
      else if (wr_en)
         q_r <= wr_data & WMASK;
   end
endmodule
`default_nettype wire

// ### design/emtc_mode_issue.v
// mode-register-set issue for the synchronous memories of areas 2 and 3
`timescale 1ns/100ps
`default_nettype none
`include "emtc_defines.vh"
module emtc_mode_issue
(
   // clock and reset
   input wire clk,
   input wire rst_n,
   // request from the window decode
   input wire req,
   input wire req_area3,
   input wire [`EMTC_SMMS_SPAN_MSB:0] req_offset,
   // command to the memory
   output reg mrs_area2_r,
   output reg mrs_area3_r,
   output reg [`EMTC_MODE_MSB:0] mrs_addr_r
);
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mrs_area2_r <= 1'b0;
         mrs_area3_r <= 1'b0;
         mrs_addr_r <= {(`EMTC_MODE_MSB+1){1'b0}};
      end
      else
      begin
         mrs_area2_r <= req & ~req_area3;
         mrs_area3_r <= req & req_area3;
         if (req)
            mrs_addr_r <= req_offset[`EMTC_SMMS_SPAN_MSB:`EMTC_MODE_SHIFT];
      end
   end
endmodule
`default_nettype wire

// ### test/emtc_top_properties.sv
// port assertions for the timing configuration block
`timescale 1ns/100ps
`default_nettype none
module emtc_top_chk
(
   // clock, reset and register port
   input wire logic clk,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [27:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata_r,
   // status and outputs
   input wire logic bus_busy,
   input wire logic [2:0] row_to_column_cycles_r,
   input wire logic [2:0] area5_lead_half_r,
   input wire logic area2_bus16_r,
   input wire logic bus_abort_r,
   input wire logic cbr_refresh_r,
   input wire logic in_self_refresh_r,
   input wire logic mrs_area2,
   input wire logic mrs_area3,
   input wire logic [9:0] mrs_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // config outputs follow a write after two edges
   sequence s_ctl_wr;
      reg_wr && reg_addr == 28'hFFFFF00 ##1 1'b1;
   endsequence
   sequence s_card_wr;
      reg_wr && reg_addr == 28'hFFFFF04 ##1 1'b1;
   endsequence
   property p_rcd;
      s_ctl_wr |=> row_to_column_cycles_r ==
         {1'b0, $past(reg_wdata[13:12], 2)} + 3'h1;
   endproperty
   a_rcd: assert property (p_rcd) else $error("rcd mismatch");
   property p_lead;
      s_card_wr |=> area5_lead_half_r == {$past(reg_wdata[7:6], 2), 1'b1};
   endproperty
   a_lead: assert property (p_lead) else $error("lead mismatch");
   property p_mrs2;
      reg_wr && reg_addr[27:12] == 16'hFFFD |=> mrs_area2 && !mrs_area3
         && mrs_addr == $past(reg_addr[11:2]);
   endproperty
   a_mrs2: assert property (p_mrs2) else $error("mode cmd bad");
   property p_nomrs;
      !(reg_wr && (reg_addr[27:12] == 16'hFFFD ||
         reg_addr[27:12] == 16'hFFFE)) |=> !mrs_area2 && !mrs_area3;
   endproperty
   a_nomrs: assert property (p_nomrs) else $error("stray mode cmd");
   property p_unused;
      reg_rd && reg_addr == 28'hFFFFF00 |=>
         (reg_rdata_r & 16'h0CA1) == 16'h0000;
   endproperty
   a_unused: assert property (p_unused) else $error("unused bit set");
   property p_bus16;
      area2_bus16_r;
   endproperty
   a_bus16: assert property (p_bus16) else $error("bus not 16");
   property p_abort;
      bus_abort_r |-> cbr_refresh_r && $past(bus_busy);
   endproperty
   a_abort: assert property (p_abort) else $error("abort bad");
   property p_self;
      $rose(in_self_refresh_r) |-> !$past(bus_busy);
   endproperty
   a_self: assert property (p_self) else $error("self early");
endmodule
bind emtc_top emtc_top_chk u_chk
(
   .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
   .bus_busy(bus_busy), .row_to_column_cycles_r(row_to_column_cycles_r),
   .area5_lead_half_r(area5_lead_half_r), .area2_bus16_r(area2_bus16_r),
   .bus_abort_r(bus_abort_r), .cbr_refresh_r(cbr_refresh_r),
   .in_self_refresh_r(in_self_refresh_r), .mrs_area2(mrs_area2),
   .mrs_area3(mrs_area3), .mrs_addr(mrs_addr)
);
`default_nettype wire

// ### test/emtc_sdram_model.sv
// sync memories of areas 2 and 3, each latching its own mode command
`timescale 1ns/100ps
`default_nettype none
module emtc_sdram_model
(
   // mode command
   input wire logic clk,
   input wire logic mrs_area2,
   input wire logic mrs_area3,
   input wire logic [9:0] mrs_addr,
   // mode held by each memory
   output var logic [9:0] mode2,
   output var logic [9:0] mode3
);
   always @(posedge clk)
   begin
      if (mrs_area2) mode2 <= mrs_addr;
      if (mrs_area3) mode3 <= mrs_addr;
   end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the timing configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk, resetn, reg_wr, reg_rd, bus_busy, refresh_req, sre;
   logic [27:0] reg_addr;
   logic [15:0] reg_wdata;
   logic [1:0] wsw;
   logic [59:0] rows [7];
   wire [15:0] rdat;
   wire [3:0] prech, colw;
   wire [1:0] csw;
   wire [9:0] maddr, mode2, mode3;
   wire bus16, abort, cbr, insr, mrs2, mrs3;
   wire burst;
   wire [2:0] ras, l5, l6, t5, t6;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   emtc_top dut
   (
      .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(rdat),
      .bus_busy(bus_busy), .refresh_req(refresh_req),
      .self_refresh_exit(sre), .wait_strobe_width(wsw),
      .precharge_cycles_r(prech), .row_to_column_cycles_r(),
      .refresh_ras_cycles_r(ras), .burst_enable_r(burst),
      .column_width_r(colw),
      .area2_bus16_r(bus16), .bus_abort_r(abort), .cbr_refresh_r(cbr),
      .in_self_refresh_r(insr), .area5_lead_half_r(l5),
      .area6_lead_half_r(l6), .area5_trail_half_r(t5),
      .area6_trail_half_r(t6), .card_strobe_width_r(csw),
      .mrs_area2(mrs2), .mrs_area3(mrs3), .mrs_addr(maddr)
   );
   emtc_sdram_model mem
   (
      .clk(clk), .mrs_area2(mrs2), .mrs_area3(mrs3), .mrs_addr(maddr),
      .mode2(mode2), .mode3(mode3)
   );
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic summarize;
      if (err_total == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // a hang ends the run as a mismatch
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         summarize;
      end
   end
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [27:0] a, input logic [15:0] d);
      @(posedge clk);
      #2 reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #2 reg_wr = 1'b0;
   endtask
   task automatic rchk(input logic [27:0] a, input logic [15:0] e);
      @(posedge clk);
      #2 reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #2 reg_rd = 1'b0;
      cmp(rdat, e);
   endtask
   task automatic pulse_req;
      @(posedge clk);
      #2 refresh_req = 1'b1;
      @(posedge clk);
      #2 refresh_req = 1'b0;
   endtask
   initial
   begin
      resetn = 1'b0;
      {reg_wr, reg_rd, bus_busy, refresh_req, sre} = 5'h00;
      reg_addr = 28'h0000000;
      reg_wdata = 16'h0000;
      wsw = 2'h3;
      rows = '{{28'hFFFFF00, 16'hFFFF, 16'hF35E},
         {28'hFFFFF00, 16'h0000, 16'h0000},
         {28'hFFFFF00, 16'h5148, 16'h5148},
         {28'hFFFFF04, 16'h00FF, 16'h00FF},
         {28'hFFFFF04, 16'h00A5, 16'h00A5},
         {28'hFFFFF08, 16'h1234, 16'h0000},
         {28'hFFFD8C0, 16'h5A5A, 16'h0000}};
      repeat (5) @(posedge clk);
      #2 resetn = 1'b1;
      repeat (3) @(posedge clk);
      #2 cmp({12'h000, prech}, 16'h0001);
      cmp({12'h000, colw}, 16'h0008);
      cmp({14'h0000, csw}, 16'h0003);
      cmp({15'h0000, bus16}, 16'h0001);
      rchk(28'hFFFFF00, 16'h0000);
      rchk(28'hFFFFF04, 16'h0000);
      for (int i = 0; i < 7; i++)
      begin
         wr(rows[i][59:32], rows[i][31:16]);
         rchk(rows[i][59:32], rows[i][15:0]);
      end
      cmp({4'h0, l5, l6, t5, t6}, 16'h0B5B);
      for (int c = 0; c < 4; c++)
      begin
         wr(28'hFFFFF00, {c[1:0], c[1:0], 2'h0, c[1:0], 1'b0, c[0], 1'b0,
            c[1:0], 3'h0});
         sre = 1'b0;
         repeat (2) @(posedge clk);
         #2 cmp({12'h000, prech}, 16'h0001 + c[15:0]);
         cmp({12'h000, colw}, 16'h0008 + c[15:0]);
         cmp({13'h0000, ras}, 16'h0002 + c[15:0]);
         cmp({15'h0000, burst}, {15'h0000, c[0]});
         sre = 1'b1;
         repeat (2) @(posedge clk);
         #2 cmp({12'h000, prech}, 16'h0002 + 16'h0003 * c[15:0]);
      end
      sre = 1'b0;
      // back to back writes, one per window, data ignored
      @(posedge clk);
      #2 reg_wr = 1'b1;
      reg_addr = 28'hFFFD8C0;
      reg_wdata = 16'hA5A5;
      @(posedge clk);
      #2 reg_addr = 28'hFFFEFFC;
      @(posedge clk);
      #2 reg_wr = 1'b0;
      @(posedge clk);
      #2 cmp({6'h00, mode2}, 16'h0230);
      cmp({6'h00, mode3}, 16'h03FF);
      pulse_req;
      cmp({14'h0000, cbr, abort}, 16'h0000);
      wr(28'hFFFFF00, 16'h0004);
      repeat (2) @(posedge clk);
      #2 bus_busy = 1'b1;
      pulse_req;
      cmp({14'h0000, cbr, abort}, 16'h0003);
      wr(28'hFFFFF00, 16'h0006);
      repeat (3) @(posedge clk);
      #2 cmp({15'h0000, insr}, 16'h0000);
      bus_busy = 1'b0;
      repeat (2) @(posedge clk);
      #2 cmp({15'h0000, insr}, 16'h0001);
      pulse_req;
      cmp({15'h0000, cbr}, 16'h0000);
      wr(28'hFFFFF00, 16'h0000);
      repeat (3) @(posedge clk);
      #2 cmp({15'h0000, insr}, 16'h0000);
      // second power-on reset in mid-run clears both registers
      resetn = 1'b0;
      repeat (2) @(posedge clk);
      #2 resetn = 1'b1;
      repeat (3) @(posedge clk);
      #2 cmp({6'h00, maddr}, 16'h0000);
      rchk(28'hFFFFF04, 16'h0000);
      summarize;
   end
endmodule
`default_nettype wire
